// *** logic/ovr_chan.sv ***
// one channel of overrange detection: compare, stretch for the pins, window for embedding
// assumes one sample per clock while valid_i is high, thresholds stable from registers
module ovr_chan (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// sample stream
	input wire logic [11:0] sample_i,
	input wire logic valid_i,
	// settings
	input wire logic [7:0] high_limit_level_i,
	input wire logic [7:0] low_limit_level_i,
	input wire logic [2:0] flag_hold_period_sel_i,
	// results
	output ovr_pkg::flag_pair_t hit_o,
	output ovr_pkg::flag_pair_t pin_o,
	output ovr_pkg::flag_pair_t emb_o
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [10:0] pin_hi;
		logic [10:0] pin_lo;
		logic [7:0] emb_hi;
		logic [7:0] emb_lo;
		ovr_pkg::flag_pair_t hit;
	} chan_state_t;

	chan_state_t st_ff;
	chan_state_t nxt_st;
	logic [7:0] mag;
	ovr_pkg::flag_pair_t hit_now;
	logic [10:0] pin_load;
	logic [7:0] emb_load;

	// reload on a hit, otherwise count down to zero when allowed
	function automatic logic [10:0] hold_next(input logic [10:0] cnt, input logic hit,
		input logic [10:0] load, input logic dec);
		if (hit) begin
			return load;
		end else if (dec && cnt != 11'h000) begin
			return cnt - 11'h001;
		end
		return cnt;
	endfunction : hold_next

	// ------------------------------------------------------------------
	// compare and count
	// ------------------------------------------------------------------
	// both thresholds are shared by every channel instance
	always_comb begin
		mag = ovr_pkg::mag_top8(sample_i);
		hit_now.hi = valid_i && (mag >= high_limit_level_i);
		hit_now.lo = valid_i && (mag >= low_limit_level_i);
		pin_load = ovr_pkg::PIN_HOLD_BASE << flag_hold_period_sel_i;
		emb_load = ovr_pkg::EMB_WIN_BASE << flag_hold_period_sel_i;
		nxt_st = st_ff;
		nxt_st.hit = hit_now;
		// pin hold counts device cycles, embedded window counts samples
		nxt_st.pin_hi = hold_next(st_ff.pin_hi, hit_now.hi, pin_load, 1'b1);
		nxt_st.pin_lo = hold_next(st_ff.pin_lo, hit_now.lo, pin_load, 1'b1);
		nxt_st.emb_hi = 8'(hold_next({3'h0, st_ff.emb_hi}, hit_now.hi, {3'h0, emb_load},
			valid_i));
		nxt_st.emb_lo = 8'(hold_next({3'h0, st_ff.emb_lo}, hit_now.lo, {3'h0, emb_load},
			valid_i));
	end

	// clock enable low freezes every counter
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
		end else if (clk_en_i) begin
			st_ff <= nxt_st;
		end
	end

	assign hit_o = st_ff.hit;
	assign pin_o = '{hi: st_ff.pin_hi != 11'h000, lo: st_ff.pin_lo != 11'h000};
	assign emb_o = '{hi: st_ff.emb_hi != 8'h00, lo: st_ff.emb_lo != 8'h00};

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_pin_set_hit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && hit_now.hi |=> pin_o.hi && hit_o.hi)
		else $error("high flag not raised after a hit");

	a_pin_min_hold: assert property (@(posedge clk_sys_i)
		disable iff (!rstn_i || !clk_en_i)
		$rose(pin_o.lo) |-> pin_o.lo[*8])
		else $error("low flag shorter than eight cycles");

	a_pin_exact_end: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(pin_o.hi) |-> $past(st_ff.pin_hi) == 11'h001 && !$past(hit_now.hi))
		else $error("high flag dropped before its hold ran out");

	a_emb_window: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && hit_now.lo |=> emb_o.lo && st_ff.emb_lo == $past(emb_load))
		else $error("embedded window not reloaded on a hit");

endmodule : ovr_chan

// *** logic/ovr_mark_top.sv ***
// overrange flagging and sample marking for a two-channel 12-bit converter
// assumes samples and trigger arrive in step with clk_sys_i; registers over AHB-Lite
//
// Notes on behaviour
// - magnitude of each 12-bit sample, top 8 bits compared to two thresholds.
// - magnitude saturates, most negative code gives 2047 and 255 compared.
// - both channels share one pair of threshold settings.
// - flag is 1 when compared bits reach threshold in the period, else 0.
// - two flag pins per channel, high and low threshold, for A and B.
// - pin flag holds 8 times 2^setting device cycles after last event.
// - decimated I LSB carries high flag, Q LSB carries low flag.
// - embedded flags only in decimating formats with control-bit count one.
// - embedded flag high on a hit within 2^setting samples.
// - marking acts only while its enable is set.
// - marked 12-bit sample is upper 11 bits plus trigger, same latency.
// - in 8-bit formats trigger replaces the LSB of the 8-bit sample.
// - trigger must be synchronous to clk_sys_i; it is taken alongside the sample.
// - marking is off whenever a decimating format is selected.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
module ovr_mark_top (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// converter samples and trigger
	input wire logic [11:0] chan_a_sample_i,
	input wire logic [11:0] chan_b_sample_i,
	input wire logic sample_valid_i,
	input wire logic sample_mark_trigger_in_i,
	// decimated complex samples
	input ovr_pkg::cplx_t ddc_a_i,
	input ovr_pkg::cplx_t ddc_b_i,
	input wire logic ddc_valid_i,
	// output samples
	output logic [11:0] chan_a_data_o,
	output logic [11:0] chan_b_data_o,
	output logic data_valid_o,
	output ovr_pkg::cplx_t ddc_a_o,
	output ovr_pkg::cplx_t ddc_b_o,
	output logic ddc_valid_o,
	// flag pins and interrupt
	output logic chan_a_high_flag_out_o,
	output logic chan_a_low_flag_out_o,
	output logic chan_b_high_flag_out_o,
	output logic chan_b_low_flag_out_o,
	output logic irq_o
);

	// ------------------------------------------------------------------
	// state and helpers
	// ------------------------------------------------------------------
	typedef struct packed {
		ovr_pkg::ctrl_t ctrl;
		logic [7:0] hi_lvl;
		logic [7:0] lo_lvl;
		logic [3:0] status;
		logic [3:0] mask;
		ovr_pkg::bus_phase_t ph;
		logic dph_write;
		logic [7:0] dph_addr;
		logic [31:0] rdata;
		logic [11:0] out_a;
		logic [11:0] out_b;
		logic out_valid;
		ovr_pkg::cplx_t dd_a;
		ovr_pkg::cplx_t dd_b;
		logic dd_valid;
		logic irq;
	} top_state_t;

	top_state_t st_ff;
	top_state_t nxt_st;
	ovr_pkg::flag_pair_t hit_a;
	ovr_pkg::flag_pair_t hit_b;
	ovr_pkg::flag_pair_t pin_a;
	ovr_pkg::flag_pair_t pin_b;
	ovr_pkg::flag_pair_t emb_a;
	ovr_pkg::flag_pair_t emb_b;
	logic [3:0] events;
	logic [3:0] w1c;
	logic addr_take;
	logic wr_go;

	// shape one converter sample for the link
	function automatic logic [11:0] fmt_sample(input logic [11:0] s, input logic trig,
		input ovr_pkg::ctrl_t c);
		logic mark;
		mark = c.mark_en && !c.decim;
		if (c.byte_fmt) begin
			return mark ? {s[11:5], trig, 4'h0} : {s[11:4], 4'h0};
		end
		return mark ? {s[11:1], trig} : s;
	endfunction : fmt_sample

	// fold the window flags into the low bits of I and Q
	function automatic ovr_pkg::cplx_t embed(input ovr_pkg::cplx_t d,
		input ovr_pkg::flag_pair_t f, input ovr_pkg::ctrl_t c);
		ovr_pkg::cplx_t r;
		r = d;
		if (c.decim && c.cs_one) begin
			r.i = {d.i[15:1], f.hi};
			r.q = {d.q[15:1], f.lo};
		end
		return r;
	endfunction : embed

	// register read map, unmapped offsets read zero
	function automatic logic [31:0] reg_read(input logic [7:0] a, input top_state_t s,
		input logic [7:0] live);
		case (a)
			ovr_pkg::OFS_CTRL: reg_read = {25'h0, s.ctrl};
			ovr_pkg::OFS_HI_LVL: reg_read = {24'h0, s.hi_lvl};
			ovr_pkg::OFS_LO_LVL: reg_read = {24'h0, s.lo_lvl};
			ovr_pkg::OFS_STATUS: reg_read = {28'h0, s.status};
			ovr_pkg::OFS_MASK: reg_read = {28'h0, s.mask};
			ovr_pkg::OFS_LIVE: reg_read = {24'h0, live};
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction : reg_read

	// ------------------------------------------------------------------
	// per-channel detectors, one shared threshold pair
	// ------------------------------------------------------------------
	ovr_chan u_chan_a (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.clk_en_i(clk_en_i),
		.sample_i(chan_a_sample_i),
		.valid_i(sample_valid_i),
		.high_limit_level_i(st_ff.hi_lvl),
		.low_limit_level_i(st_ff.lo_lvl),
		.flag_hold_period_sel_i(st_ff.ctrl.period_sel),
		.hit_o(hit_a),
		.pin_o(pin_a),
		.emb_o(emb_a)
	);

	ovr_chan u_chan_b (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.clk_en_i(clk_en_i),
		.sample_i(chan_b_sample_i),
		.valid_i(sample_valid_i),
		.high_limit_level_i(st_ff.hi_lvl),
		.low_limit_level_i(st_ff.lo_lvl),
		.flag_hold_period_sel_i(st_ff.ctrl.period_sel),
		.hit_o(hit_b),
		.pin_o(pin_b),
		.emb_o(emb_b)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// zero-wait slave: read data is fetched at the address phase, so a read
	// that directly follows a write to the same word would see the old value
	always_comb begin
		addr_take = hsel_i && htrans_i[1] && hready_i;
		wr_go = (st_ff.ph == ovr_pkg::PH_DATA) && st_ff.dph_write;
		events = '0;
		events[ovr_pkg::STS_A_HI] = hit_a.hi;
		events[ovr_pkg::STS_A_LO] = hit_a.lo;
		events[ovr_pkg::STS_B_HI] = hit_b.hi;
		events[ovr_pkg::STS_B_LO] = hit_b.lo;
		w1c = '0;
		nxt_st = st_ff;
		// register writes in the data phase
		if (wr_go) begin
			case (st_ff.dph_addr)
				ovr_pkg::OFS_CTRL: nxt_st.ctrl = ovr_pkg::ctrl_t'(hwdata_i[6:0]);
				ovr_pkg::OFS_HI_LVL: nxt_st.hi_lvl = hwdata_i[7:0];
				ovr_pkg::OFS_LO_LVL: nxt_st.lo_lvl = hwdata_i[7:0];
				ovr_pkg::OFS_STATUS: w1c = hwdata_i[3:0];
				ovr_pkg::OFS_MASK: nxt_st.mask = hwdata_i[3:0];
				default: nxt_st.ctrl = st_ff.ctrl; // unmapped writes are dropped
			endcase
		end
		// set wins over a clear in the same cycle
		nxt_st.status = (st_ff.status & ~w1c) | events;
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
		// bus phase tracking
		if (addr_take) begin
			nxt_st.ph = ovr_pkg::PH_DATA;
			nxt_st.dph_write = hwrite_i;
			nxt_st.dph_addr = haddr_i[7:0];
			nxt_st.rdata = reg_read(haddr_i[7:0], st_ff,
				{emb_b, emb_a, pin_b, pin_a});
		end else begin
			nxt_st.ph = ovr_pkg::PH_IDLE;
			nxt_st.dph_write = 1'b0;
		end
		// sample and trigger share one register stage, so latency matches
		nxt_st.out_valid = sample_valid_i;
		if (sample_valid_i) begin
			nxt_st.out_a = fmt_sample(chan_a_sample_i, sample_mark_trigger_in_i,
				st_ff.ctrl);
			nxt_st.out_b = fmt_sample(chan_b_sample_i, sample_mark_trigger_in_i,
				st_ff.ctrl);
		end
		nxt_st.dd_valid = ddc_valid_i;
		if (ddc_valid_i) begin
			nxt_st.dd_a = embed(ddc_a_i, emb_a, st_ff.ctrl);
			nxt_st.dd_b = embed(ddc_b_i, emb_b, st_ff.ctrl);
		end
	end

	// one register stage for all state, frozen while the enable is low
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= '0;
			st_ff.ctrl <= ovr_pkg::CTRL_RST;
			st_ff.hi_lvl <= ovr_pkg::HI_LVL_RST;
			st_ff.lo_lvl <= ovr_pkg::LO_LVL_RST;
			st_ff.mask <= ovr_pkg::MASK_RST;
		end else if (clk_en_i) begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// hready follows the enable so a frozen block stalls the master
	assign hreadyout_o = clk_en_i;
	assign hresp_o = 1'b0;
	assign hrdata_o = st_ff.rdata;
	assign chan_a_data_o = st_ff.out_a;
	assign chan_b_data_o = st_ff.out_b;
	assign data_valid_o = st_ff.out_valid;
	assign ddc_a_o = st_ff.dd_a;
	assign ddc_b_o = st_ff.dd_b;
	assign ddc_valid_o = st_ff.dd_valid;
	// receiver ORs A and B per threshold in single-channel mode
	assign chan_a_high_flag_out_o = pin_a.hi;
	assign chan_a_low_flag_out_o = pin_a.lo;
	assign chan_b_high_flag_out_o = pin_b.hi;
	assign chan_b_low_flag_out_o = pin_b.lo;
	assign irq_o = st_ff.irq;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_mark_lsb_trig: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && sample_valid_i && st_ff.ctrl.mark_en && !st_ff.ctrl.decim
		&& !st_ff.ctrl.byte_fmt && $stable(st_ff.ctrl)
		|=> chan_a_data_o == {$past(chan_a_sample_i[11:1]), $past(sample_mark_trigger_in_i)})
		else $error("marked sample does not carry trigger in its LSB");

	a_byte_mark_lsb: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && sample_valid_i && st_ff.ctrl.mark_en && !st_ff.ctrl.decim
		&& st_ff.ctrl.byte_fmt
		|=> chan_b_data_o[4] == $past(sample_mark_trigger_in_i))
		else $error("8-bit sample LSB is not the trigger");

	a_no_mark_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && sample_valid_i && (!st_ff.ctrl.mark_en || st_ff.ctrl.decim)
		&& !st_ff.ctrl.byte_fmt |=> chan_a_data_o == $past(chan_a_sample_i))
		else $error("unmarked sample lost converter data");

	a_embed_i_lsb: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && ddc_valid_i && st_ff.ctrl.decim && st_ff.ctrl.cs_one
		|=> ddc_a_o.i[0] == $past(emb_a.hi) && ddc_b_o.q[0] == $past(emb_b.lo))
		else $error("embedded flag missing from complex sample");

	a_embed_off_raw: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && ddc_valid_i && !(st_ff.ctrl.decim && st_ff.ctrl.cs_one)
		|=> ddc_a_o == $past(ddc_a_i))
		else $error("flag embedded outside its format");

	a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && st_ff.status[0] && !(wr_go && st_ff.dph_addr == ovr_pkg::OFS_STATUS)
		|=> st_ff.status[0])
		else $error("status bit cleared without a write");

	a_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && |(events & st_ff.mask) && !(wr_go && st_ff.dph_addr == ovr_pkg::OFS_MASK)
		|=> irq_o)
		else $error("unmasked event did not raise the interrupt");

	a_shared_level: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		clk_en_i && wr_go && st_ff.dph_addr == ovr_pkg::OFS_LO_LVL
		|=> st_ff.lo_lvl == $past(hwdata_i[7:0]) && $stable(st_ff.hi_lvl))
		else $error("threshold write not independent");

endmodule : ovr_mark_top

// *** logic/ovr_pkg.sv ***
// package for the overrange detector and sample-marking block
// holds register map, field positions, reset values, carrier types and shared math
// assumes one sampling clock; every user writes ovr_pkg::name, nothing is imported
package ovr_pkg;

	// ------------------------------------------------------------------
	// widths and counts
	// ------------------------------------------------------------------
	localparam int unsigned SMP_W = 12;
	localparam int unsigned DDC_W = 16;
	localparam int unsigned LVL_W = 8;
	localparam int unsigned SEL_W = 3;
	localparam int unsigned PIN_CNT_W = 11;
	localparam int unsigned EMB_CNT_W = 8;
	localparam logic [PIN_CNT_W-1:0] PIN_HOLD_BASE = 11'h008; // device cycles at setting 0
	localparam logic [EMB_CNT_W-1:0] EMB_WIN_BASE = 8'h01; // samples at setting 0

	// ------------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HI_LVL = 8'h04;
	localparam logic [7:0] OFS_LO_LVL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_LIVE = 8'h14;

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned CTRL_MARK_EN_BIT = 0;
	localparam int unsigned CTRL_DECIM_BIT = 1;
	localparam int unsigned CTRL_CS_ONE_BIT = 2;
	localparam int unsigned CTRL_BYTE_FMT_BIT = 3;
	localparam int unsigned CTRL_PERIOD_LSB = 4;
	localparam int unsigned STS_A_HI = 0;
	localparam int unsigned STS_A_LO = 1;
	localparam int unsigned STS_B_HI = 2;
	localparam int unsigned STS_B_LO = 3;
	localparam logic [LVL_W-1:0] HI_LVL_RST = 8'hE4;
	localparam logic [LVL_W-1:0] LO_LVL_RST = 8'h40;
	localparam logic [3:0] MASK_RST = 4'h0;

	// ------------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [SEL_W-1:0] period_sel;
		logic byte_fmt;
		logic cs_one;
		logic decim;
		logic mark_en;
	} ctrl_t;

	typedef struct packed {
		logic hi;
		logic lo;
	} flag_pair_t;

	typedef struct packed {
		logic [DDC_W-1:0] i;
		logic [DDC_W-1:0] q;
	} cplx_t;

	typedef enum logic [0:0] {PH_IDLE = 1'b0, PH_DATA = 1'b1} bus_phase_t;

	localparam ctrl_t CTRL_RST = '{period_sel: 3'h0, byte_fmt: 1'b0, cs_one: 1'b0,
		decim: 1'b0, mark_en: 1'b0};

	// saturating magnitude, upper eight of its eleven bits
	function automatic logic [LVL_W-1:0] mag_top8(input logic [SMP_W-1:0] s);
		logic [SMP_W-1:0] neg;
		logic [SMP_W-2:0] mag;
		neg = ~s + 12'h001;
		if (!s[SMP_W-1]) begin
			mag = s[SMP_W-2:0];
		end else if (s == 12'h800) begin
			mag = 11'h7FF; // most negative code would wrap to zero
		end else begin
			mag = neg[SMP_W-2:0];
		end
		return mag[SMP_W-2:3];
	endfunction : mag_top8

endpackage : ovr_pkg

// *** verif/ovr_sink.sv ***
// downstream logic model: merges the flag pins and decides on gain steps
// assumes the flag pins are synchronous levels on clk_sys_i
module ovr_sink #(
	parameter int QUIET_LEN = 64
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// flag pins from the converter
	input wire logic a_high_i,
	input wire logic a_low_i,
	input wire logic b_high_i,
	input wire logic b_low_i,
	// merged view and gain request
	output logic high_any_o,
	output logic low_any_o,
	output logic gain_up_o
);
	// ------------------------------------------------------------------
	// flag merge and gain control
	// ------------------------------------------------------------------
	int quiet_cnt;

	// either half of an interleaved channel may carry the event
	assign high_any_o = a_high_i | b_high_i;
	assign low_any_o = a_low_i | b_low_i;

	// a long quiet low-threshold flag means headroom, so more gain is asked for
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			quiet_cnt <= 0;
		end else if (low_any_o) begin
			quiet_cnt <= 0;
		end else if (quiet_cnt < QUIET_LEN) begin
			quiet_cnt <= quiet_cnt + 1;
		end
	end
	assign gain_up_o = (quiet_cnt == QUIET_LEN);
endmodule : ovr_sink

// *** verif/tb.sv ***
// self-checking bench for ovr_mark_top: thresholds, flag pins, marking, embedding, irq
// assumes zero wait states on the bus while clk_en_i is high
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------------
	// signals and table
	// ------------------------------------------------------------------
	typedef struct {
		logic [7:0] ctrl;
		logic [7:0] hi;
		logic [7:0] lo;
		logic [11:0] sa;
		logic [11:0] sb;
		logic trig;
		logic [3:0] pins;
		logic [11:0] da;
		logic [11:0] db;
	} row_t;
	logic clk_sys_i, rstn_i, hsel, hwrite, hready, hresp, valid, trig, ddc_vin, irq;
	logic [31:0] haddr, hwdata, hrdata, rd, n;
	logic [1:0] htrans;
	logic [11:0] sa, sb, da, db;
	logic [3:0] pins;
	logic hi_any, lo_any;
	logic dv, ddc_vo, gain_up, clk_en;
	ovr_pkg::cplx_t ddc_in, ddc_ao, ddc_bo;
	int mismatches, cmp_count;
	// pins order: a high, a low, b high, b low
	row_t rows [11] = '{
		'{8'h00, 8'hE4, 8'h40, 12'h7FF, 12'h000, 1'b0, 4'hC, 12'h7FF, 12'h000},
		'{8'h00, 8'hE4, 8'h40, 12'h800, 12'h810, 1'b0, 4'hF, 12'h800, 12'h810},
		'{8'h00, 8'hE4, 8'h40, 12'h720, 12'h71F, 1'b0, 4'hD, 12'h720, 12'h71F},
		'{8'h00, 8'hE4, 8'h40, 12'h200, 12'h1FF, 1'b0, 4'h4, 12'h200, 12'h1FF},
		'{8'h00, 8'h10, 8'h70, 12'h100, 12'hE00, 1'b0, 4'hA, 12'h100, 12'hE00},
		'{8'h01, 8'hE4, 8'h40, 12'h7FF, 12'h000, 1'b0, 4'hC, 12'h7FE, 12'h000},
		'{8'h01, 8'hE4, 8'h40, 12'h000, 12'h000, 1'b1, 4'h0, 12'h001, 12'h001},
		'{8'h09, 8'hE4, 8'h40, 12'h7FF, 12'h000, 1'b0, 4'hC, 12'h7E0, 12'h000},
		'{8'h09, 8'hE4, 8'h40, 12'h000, 12'h000, 1'b1, 4'h0, 12'h010, 12'h010},
		'{8'h03, 8'hE4, 8'h40, 12'h7FF, 12'h000, 1'b1, 4'hC, 12'h7FF, 12'h000},
		'{8'h00, 8'hE4, 8'h40, 12'h7FE, 12'h000, 1'b1, 4'hC, 12'h7FE, 12'h000}};

	ovr_mark_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_en_i(clk_en),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(hresp), .hrdata_o(hrdata), .chan_a_sample_i(sa), .chan_b_sample_i(sb),
		.sample_valid_i(valid), .sample_mark_trigger_in_i(trig), .ddc_a_i(ddc_in),
		.ddc_b_i(ddc_in), .ddc_valid_i(ddc_vin), .chan_a_data_o(da), .chan_b_data_o(db),
		.data_valid_o(dv), .ddc_a_o(ddc_ao), .ddc_b_o(ddc_bo), .ddc_valid_o(ddc_vo),
		.chan_a_high_flag_out_o(pins[3]), .chan_a_low_flag_out_o(pins[2]),
		.chan_b_high_flag_out_o(pins[1]), .chan_b_low_flag_out_o(pins[0]), .irq_o(irq));

	ovr_sink sink_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .a_high_i(pins[3]),
		.a_low_i(pins[2]), .b_high_i(pins[1]), .b_low_i(pins[0]), .high_any_o(hi_any),
		.low_any_o(lo_any), .gain_up_o(gain_up));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task close_out;
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// waits for hready at a rising edge, bounded so a hang ends the run
	task wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (k >= 50) begin
			mismatches++;
			close_out();
		end
	endtask : wait_rdy

	// one single-word transfer; called just after a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : bus

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(rd, exp);
	endtask : rd_chk

	// one valid sample on both channels; returns one ns after the taking edge
	task send(input logic [11:0] a, input logic [11:0] b, input logic t);
		sa <= a;
		sb <= b;
		trig <= t;
		valid <= 1'b1;
		@(posedge clk_sys_i);
		valid <= 1'b0;
		#1;
	endtask : send

	task ddc(input ovr_pkg::cplx_t v, input ovr_pkg::cplx_t exp);
		ddc_in <= v;
		ddc_vin <= 1'b1;
		@(posedge clk_sys_i);
		ddc_vin <= 1'b0;
		#1;
		check(ddc_ao, exp);
		check(ddc_bo, exp);
		check(32'(ddc_vo), 32'h1);
	endtask : ddc

	// ------------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		{rstn_i, hsel, hwrite, valid, trig, ddc_vin, htrans} = '0;
		{haddr, hwdata, sa, sb, ddc_in} = '0;
		clk_en = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		// ordinary cases: thresholds, saturation, marking formats
		foreach (rows[k]) begin
			bus(1'b1, ovr_pkg::OFS_CTRL, 32'(rows[k].ctrl));
			bus(1'b1, ovr_pkg::OFS_HI_LVL, 32'(rows[k].hi));
			bus(1'b1, ovr_pkg::OFS_LO_LVL, 32'(rows[k].lo));
			send(rows[k].sa, rows[k].sb, rows[k].trig);
			check(32'(pins), 32'(rows[k].pins));
			check(32'(da), 32'(rows[k].da));
			check(32'(db), 32'(rows[k].db));
			check(32'(dv), 32'h1);
			check(32'({hi_any, lo_any}), 32'({|rows[k].pins[3:2] & rows[k].pins[3] | rows[k].pins[1],
				rows[k].pins[2] | rows[k].pins[0]}));
			repeat (12) @(posedge clk_sys_i);
		end
		// sticky status, mask and clear by writing ones
		rd_chk(ovr_pkg::OFS_STATUS, 32'h0000000F);
		check(32'(irq), 32'h0);
		bus(1'b1, ovr_pkg::OFS_MASK, 32'h00000001);
		repeat (2) @(posedge clk_sys_i);
		#1;
		check(32'(irq), 32'h1);
		bus(1'b1, ovr_pkg::OFS_STATUS, 32'h00000001);
		rd_chk(ovr_pkg::OFS_STATUS, 32'h0000000E);
		repeat (2) @(posedge clk_sys_i);
		#1;
		check(32'(irq), 32'h0);
		// pulse length for every hold setting, counted from a retriggering hit
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, ovr_pkg::OFS_CTRL, 32'(s << 4));
			send(12'h7FF, 12'h000, 1'b0);
			repeat (3) @(posedge clk_sys_i);
			send(12'h7FF, 12'h000, 1'b0);
			n = 0;
			while (pins[3] === 1'b1 && n < 2000) begin
				n++;
				@(posedge clk_sys_i);
				#1;
			end
			check(n, 32'(8 << s));
		end
		// embedded flags: quiet window first, then a hit, then raw pass-through
		bus(1'b1, ovr_pkg::OFS_CTRL, 32'h00000016);
		// the longest window from the pulse loop must drain before the quiet check
		repeat (130) send(12'h000, 12'h000, 1'b0);
		ddc({16'hABCD, 16'h1234}, {16'hABCC, 16'h1234});
		send(12'h7FF, 12'h7FF, 1'b0);
		ddc({16'hABCD, 16'h1234}, {16'hABCD, 16'h1235});
		bus(1'b1, ovr_pkg::OFS_CTRL, 32'h00000012);
		ddc({16'hABCC, 16'h1234}, {16'hABCC, 16'h1234});
		// window at setting one lasts two samples: the hit and the one sample after it
		bus(1'b1, ovr_pkg::OFS_CTRL, 32'h00000016);
		send(12'h000, 12'h000, 1'b0);
		ddc({16'hABCC, 16'h1234}, {16'hABCD, 16'h1235});
		send(12'h000, 12'h000, 1'b0);
		ddc({16'hABCC, 16'h1234}, {16'hABCC, 16'h1234});
		// second reset in mid-run, then reset values and an unmapped word
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		check(32'(pins), 32'h0);
		check(32'(hresp), 32'h0);
		rd_chk(ovr_pkg::OFS_CTRL, 32'h00000000);
		rd_chk(ovr_pkg::OFS_HI_LVL, 32'(ovr_pkg::HI_LVL_RST));
		rd_chk(ovr_pkg::OFS_LO_LVL, 32'(ovr_pkg::LO_LVL_RST));
		rd_chk(ovr_pkg::OFS_STATUS, 32'h00000000);
		rd_chk(ovr_pkg::OFS_MASK, 32'h00000000);
		bus(1'b1, 8'h18, 32'hFFFFFFFF);
		rd_chk(8'h18, 32'h00000000);
		// frozen block takes no sample and stalls the bus
		clk_en <= 1'b0;
		send(12'h7FF, 12'h7FF, 1'b0);
		check(32'({pins, dv, hready}), 32'h0);
		clk_en <= 1'b1;
		// partner asks for gain after a long quiet low flag, and stops on a hit
		repeat (64) @(posedge clk_sys_i);
		#1;
		check(32'(gain_up), 32'h1);
		send(12'h200, 12'h000, 1'b0);
		@(posedge clk_sys_i);
		#1;
		check(32'(gain_up), 32'h0);
		close_out();
	end
endmodule : tb
